// ---- logic/rsd_pkg.sv ----
package rsd_pkg;

  // register offsets (printed offsets are not multiples of four: kept as indices)
  localparam logic [7:0] RSD_IDX_REG_TIMER = 8'h2b;
  localparam logic [7:0] RSD_IDX_PEAKS     = 8'h2c;
  localparam logic [7:0] RSD_IDX_GAIN      = 8'h2d;
  localparam logic [7:0] RSD_IDX_RSVD_A    = 8'h2e;
  localparam logic [7:0] RSD_IDX_RSVD_B    = 8'h2f;
  localparam logic [7:0] RSD_IDX_AUX       = 8'h30;
  // control register of our own: bit 0 sets default, bit 1 clears peaks
  localparam logic [7:0] RSD_IDX_CTRL      = 8'h3f;
  localparam int         RSD_CTRL_DEFAULT  = 0;
  localparam int         RSD_CTRL_PEAKCLR  = 1;

  // field positions
  localparam int RSD_REG_CODE_LSB = 4;
  localparam int RSD_GPT_BIT      = 2;
  localparam int RSD_NRT_BIT      = 1;
  localparam int RSD_MRT_BIT      = 0;
  localparam int RSD_AMP_LSB      = 4;
  localparam int RSD_PHS_LSB      = 0;
  localparam int RSD_CHSEL_BIT    = 7;

  // values after reset, and the lowest regulator code
  localparam logic [3:0] RSD_REG_CODE_MAX = 4'hf;
  localparam logic [3:0] RSD_REG_CODE_MIN = 4'h5;
  localparam logic [3:0] RSD_LEVEL_RESET  = 4'h0;
  localparam logic [7:0] RSD_BYTE_ZERO    = 8'h00;

  localparam logic [1:0] RSD_RESP_OKAY   = 2'b00;
  localparam logic [1:0] RSD_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [3:0] amp;
    logic [3:0] phs;
  } rsd_pair_t;

  typedef struct packed {
    logic gpt;
    logic nrt;
    logic mrt;
  } rsd_timers_t;

endpackage

// ---- logic/rsd_peak_hold.sv ----
`timescale 1ns/10ps
module rsd_peak_hold
  import rsd_pkg::*;
#(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // control
  input  wire logic         clr,
  input  wire logic         smp_valid,
  input  wire logic [W-1:0] level,
  // held peak
  output logic      [W-1:0] peak
);

  logic [W-1:0] peak_ff;
  logic [W-1:0] nxt_peak;
  wire          higher = smp_valid && (level > peak_ff);

  // a clear beats a sample of the same cycle; the new message starts empty
  assign nxt_peak = clr ? {W{1'b0}} : (higher ? level : peak_ff);
  assign peak     = peak_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_ff <= {W{1'b0}};
    end else begin
      peak_ff <= nxt_peak;
    end
  end

endmodule

// ---- logic/rsd_regs.sv ----
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module rsd_regs
  import rsd_pkg::*;
#(
  parameter int LW = 4
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite write address and data
  input  wire logic [9:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // axi4-lite read
  input  wire logic [9:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // regulator sources, same clock
  input  wire logic          reg_src_ext,
  input  wire logic [3:0]    reg_ext_code,
  input  wire logic          adj_done,
  input  wire logic [3:0]    adj_code,
  // timers, same clock
  input  wire rsd_timers_t   timers_run,
  // receiver, same clock
  input  wire logic          msg_start,
  input  wire logic          level_valid,
  input  wire rsd_pair_t     level_in,
  input  wire rsd_pair_t     gain_cut_in,
  input  wire logic          chan_sel,
  // selected channel level for internal use
  output logic [LW-1:0]      sel_level,
  output logic               set_default
);

  logic [3:0]  adj_code_ff;
  logic [3:0]  nxt_adj_code;
  rsd_pair_t   gain_ff;
  logic        chan_ff;
  logic        aw_ff;
  logic        w_ff;
  logic        bvalid_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [1:0]  bresp_ff;
  logic [7:0]  awidx_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic [3:0]  amp_channel_peak_level;
  logic [3:0]  phase_channel_peak_level;

  // write path: address and data taken in either order
  wire       aw_take  = s_axi_awvalid && !aw_ff && !bvalid_ff;
  wire       w_take   = s_axi_wvalid && !w_ff && !bvalid_ff;
  wire       aw_have  = aw_ff || aw_take;
  wire       w_have   = w_ff || w_take;
  wire       wr_fire  = aw_have && w_have && !bvalid_ff;
  wire [7:0] wr_idx   = aw_ff ? awidx_ff : s_axi_awaddr[9:2];
  wire [31:0] wr_data = w_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] wr_strb  = w_ff ? wstrb_ff : s_axi_wstrb;
  wire       wr_ctrl  = wr_fire && (wr_idx == RSD_IDX_CTRL) && wr_strb[0];
  wire       wr_disp  = (wr_idx >= RSD_IDX_REG_TIMER) && (wr_idx <= RSD_IDX_AUX);
  wire       wr_known = wr_disp || (wr_idx == RSD_IDX_CTRL);

  assign set_default = wr_ctrl && wr_data[RSD_CTRL_DEFAULT];
  wire   peak_clr    = msg_start || set_default
                       || (wr_ctrl && wr_data[RSD_CTRL_PEAKCLR]);

  assign s_axi_awready = aw_take;
  assign s_axi_wready  = w_take;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // read path: one cycle from address to data
  wire       rd_take = s_axi_arvalid && !rvalid_ff;
  wire [7:0] rd_idx  = s_axi_araddr[9:2];
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // regulator code in force
  assign nxt_adj_code = adj_done ? adj_code : adj_code_ff;
  wire [3:0] reg_code = reg_src_ext ? reg_ext_code : adj_code_ff;

  // peak holders, one per channel; index 1 is amplitude, 0 is phase, as in the packed pair
  logic [1:0][3:0] lvl_ch;
  logic [1:0][3:0] peak_ch;
  assign lvl_ch = level_in;

  for (genvar ch = 0; ch < 2; ch++) begin : g_peak
    rsd_peak_hold #(
      .W(4)
    ) u_peak (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .clr       (peak_clr),
      .smp_valid (level_valid),
      .level     (lvl_ch[ch]),
      .peak      (peak_ch[ch])
    );
  end

  assign amp_channel_peak_level   = peak_ch[1];
  assign phase_channel_peak_level = peak_ch[0];

  // the logic uses the level of the selected channel
  assign sel_level = chan_ff ? LW'(phase_channel_peak_level) : LW'(amp_channel_peak_level);

  wire [7:0] stat_byte = {reg_code, 1'b0, timers_run.gpt, timers_run.nrt, timers_run.mrt};
  wire [7:0] peak_byte = {amp_channel_peak_level, phase_channel_peak_level};
  wire [7:0] gain_byte = {gain_ff.amp, gain_ff.phs};
  wire [7:0] aux_byte  = {chan_ff, 7'h00};

  // reserved offsets answer zero and okay
  wire [7:0] rd_byte =
    (rd_idx == RSD_IDX_REG_TIMER) ? stat_byte :
    (rd_idx == RSD_IDX_PEAKS)     ? peak_byte :
    (rd_idx == RSD_IDX_GAIN)      ? gain_byte :
    (rd_idx == RSD_IDX_AUX)       ? aux_byte  :
    RSD_BYTE_ZERO;
  wire rd_known = ((rd_idx >= RSD_IDX_REG_TIMER) && (rd_idx <= RSD_IDX_AUX)) || (rd_idx == RSD_IDX_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn || set_default) begin
      adj_code_ff <= RSD_REG_CODE_MAX;
      gain_ff     <= '0;
      chan_ff     <= 1'b0;
    end else begin
      adj_code_ff <= nxt_adj_code;
      gain_ff     <= gain_cut_in;
      chan_ff     <= chan_sel;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awidx_ff  <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RSD_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awidx_ff <= s_axi_awaddr[9:2];
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      aw_ff <= aw_have && !wr_fire;
      w_ff  <= w_have && !wr_fire;
      // display writes complete okay and change nothing
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_known ? RSD_RESP_OKAY : RSD_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RSD_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h00_0000, rd_byte};
      rresp_ff  <= rd_known ? RSD_RESP_OKAY : RSD_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // each read word is loaded at the edge that takes its address, so checks look one edge later
  sequence s_rd_stat;
    rd_take && rd_idx == RSD_IDX_REG_TIMER;
  endsequence
  sequence s_rd_gain;
    rd_take && rd_idx == RSD_IDX_GAIN;
  endsequence
  sequence s_rd_aux;
    rd_take && rd_idx == RSD_IDX_AUX;
  endsequence
  sequence s_rd_rsvd;
    rd_take && (rd_idx == RSD_IDX_RSVD_A || rd_idx == RSD_IDX_RSVD_B);
  endsequence

  AST_GPT_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_stat |=> rdata_ff[RSD_GPT_BIT] == $past(timers_run.gpt))
    else $error("gpt run flag wrong");
  AST_NRT_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_stat |=> rdata_ff[RSD_NRT_BIT] == $past(timers_run.nrt))
    else $error("nrt run flag wrong");
  AST_MRT_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_stat |=> rdata_ff[RSD_MRT_BIT] == $past(timers_run.mrt))
    else $error("mrt run flag wrong");
  AST_BIT3_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_stat |=> rdata_ff[3] == 1'b0)
    else $error("status bit 3 not zero");
  AST_REG_DEFAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    set_default |=> adj_code_ff == RSD_REG_CODE_MAX) else $error("default voltage code wrong");
  AST_REG_SRC: assert property (@(posedge aclk) disable iff (!aresetn)
    !reg_src_ext && !adj_done && !set_default ##1 !reg_src_ext |-> stat_byte[7:4] == $past(stat_byte[7:4]))
    else $error("voltage code moved without adjust");
  AST_EXT_SRC: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_src_ext |-> stat_byte[7:RSD_REG_CODE_LSB] == reg_ext_code) else $error("external code not used");

  sequence s_clear;
    peak_clr;
  endsequence
  sequence s_quiet;
    !level_valid && !peak_clr;
  endsequence
  AST_PEAK_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    s_clear ##1 s_quiet |-> peak_byte == RSD_BYTE_ZERO) else $error("peaks not cleared");
  AST_AMP_MONO: assert property (@(posedge aclk) disable iff (!aresetn)
    !peak_clr |=> amp_channel_peak_level >= $past(amp_channel_peak_level))
    else $error("amp peak dropped");
  AST_PHS_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !peak_clr && level_valid |=> phase_channel_peak_level >= $past(level_in.phs))
    else $error("phase peak missed");
  AST_GAIN_TRACK: assert property (@(posedge aclk) disable iff (!aresetn)
    !set_default |=> gain_byte == $past(gain_cut_in)) else $error("gain state stale");
  AST_DEF_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    set_default |=> gain_byte == RSD_BYTE_ZERO && peak_byte == RSD_BYTE_ZERO)
    else $error("default did not zero");
  AST_WR_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_disp && !msg_start && !adj_done |=> stat_byte[7:4] == $past(stat_byte[7:4]) || reg_src_ext)
    else $error("display write changed state");
  AST_RSVD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && (rd_idx == RSD_IDX_RSVD_A || rd_idx == RSD_IDX_RSVD_B) |=> rdata_ff == 32'h0000_0000)
    else $error("reserved not zero");
  AST_CHSEL: assert property (@(posedge aclk) disable iff (!aresetn)
    chan_ff |-> sel_level == LW'(phase_channel_peak_level)) else $error("channel select wrong");

  // no disable here: this one watches the reset itself
  AST_RESET_VALUES: assert property (@(posedge aclk)
    !aresetn |=> adj_code_ff == RSD_REG_CODE_MAX && gain_byte == RSD_BYTE_ZERO && peak_byte == RSD_BYTE_ZERO)
    else $error("reset values wrong");
  AST_AMP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !peak_clr && level_valid |=> amp_channel_peak_level >= $past(level_in.amp))
    else $error("amp peak missed");
  AST_PHS_MONO: assert property (@(posedge aclk) disable iff (!aresetn)
    !peak_clr |=> phase_channel_peak_level >= $past(phase_channel_peak_level))
    else $error("phase peak dropped");
  AST_PEAK_STILL: assert property (@(posedge aclk) disable iff (!aresetn)
    !peak_clr && !level_valid |=> $stable(peak_byte))
    else $error("peaks moved without a sample");
  AST_AUX_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_aux |=> rdata_ff[RSD_CHSEL_BIT] == $past(chan_ff))
    else $error("aux channel bit wrong");
  AST_GAIN_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_gain |=> rdata_ff[7:0] == $past(gain_ff))
    else $error("gain read wrong");
  AST_RSVD_OKAY: assert property (@(posedge aclk) disable iff (!aresetn)
    s_rd_rsvd |=> rresp_ff == RSD_RESP_OKAY)
    else $error("reserved read refused");
  AST_DISP_OKAY: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wr_disp |=> s_axi_bresp == RSD_RESP_OKAY)
    else $error("display write refused");
  // unmapped reads answer an error so software notices a wrong index
  AST_SLVERR: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && !rd_known |=> rresp_ff == RSD_RESP_SLVERR)
    else $error("unmapped read not refused");
  AST_HIGH_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_ff |-> rdata_ff[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

endmodule

// ---- bench/tb_receiver_status_display_regs.sv ----
`timescale 1ns/10ps
module tb_receiver_status_display_regs;
  import rsd_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, ext_code, adj_code, sel_level;
  logic [1:0]  bresp, rresp;
  logic        src_ext, adj_done, msg_start, level_valid, chan_sel, set_default;
  rsd_timers_t timers;
  rsd_pair_t   lvl, gain;
  int          n_mismatch, n_checks, n_default;
  logic [3:0]  pa, pp, code;
  logic [31:0] d;
  logic [1:0]  r;
  rsd_regs rsd_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reg_src_ext(src_ext),
    .reg_ext_code(ext_code), .adj_done(adj_done), .adj_code(adj_code), .timers_run(timers),
    .msg_start(msg_start), .level_valid(level_valid), .level_in(lvl), .gain_cut_in(gain),
    .chan_sel(chan_sel), .sel_level(sel_level), .set_default(set_default));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // counts default pulses, sampled at the edge at which the write is taken
  always @(posedge aclk) begin
    if (set_default === 1'b1) n_default <= n_default + 1;
  end
  function automatic logic [9:0] ba(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction
  function automatic logic [3:0] mx(input logic [3:0] a, input logic [3:0] b);
    return (a > b) ? a : b;
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // no cycle count is assumed here; only the watchdog ends a wait that never ends
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata; rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    axi_rd(ba(idx), d, r);
    check(d, exp);
    check({30'h0000_0000, r}, {30'h0000_0000, RSD_RESP_OKAY});
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; src_ext = 1'b0; ext_code = 4'h0; adj_done = 1'b0;
    adj_code = 4'h0; timers = '0; msg_start = 1'b0; level_valid = 1'b0; lvl = '0; gain = '0; chan_sel = 1'b0;
    n_mismatch = 0; n_checks = 0; n_default = 0; pa = 4'h0; pp = 4'h0;
    d = $urandom(32'h99ea79f9);
    tick(12);
    aresetn <= 1'b1;
    rd_chk(RSD_IDX_REG_TIMER, 32'h0000_00f0);
    rd_chk(RSD_IDX_PEAKS, 32'h0000_0000);
    rd_chk(RSD_IDX_GAIN, 32'h0000_0000);
    rd_chk(RSD_IDX_AUX, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      code = (i == 0) ? 4'h5 : (i == 1) ? 4'hf : 4'(5 + $urandom % 11);
      src_ext <= i[0]; ext_code <= code; adj_done <= ~i[0]; adj_code <= code; timers <= 3'($urandom);
      tick(1);
      adj_done <= 1'b0;
      tick(2);
      rd_chk(RSD_IDX_REG_TIMER, {24'h0000_00, code, 1'b0, timers});
    end
    $display("test regulator and timers done");
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      lvl <= rsd_pair_t'(8'($urandom)); level_valid <= 1'b1; msg_start <= (i == 20);
      @(posedge aclk);
      level_valid <= 1'b0; msg_start <= 1'b0;
      // a clear in the same cycle as a sample wins
      if (i == 20) begin pa = 4'h0; pp = 4'h0; end
      else begin pa = mx(pa, lvl.amp); pp = mx(pp, lvl.phs); end
      if (i % 10 == 9) rd_chk(RSD_IDX_PEAKS, {24'h0000_00, pa, pp});
    end
    for (int c = 0; c < 2; c++) begin
      chan_sel <= c[0]; gain <= rsd_pair_t'(8'($urandom));
      tick(3);
      check({28'h0000_000, sel_level}, {28'h0000_000, c[0] ? pp : pa});
      rd_chk(RSD_IDX_AUX, {24'h0000_00, c[0], 7'h00});
      rd_chk(RSD_IDX_GAIN, {24'h0000_00, gain});
    end
    for (int k = 0; k < 6; k++) begin
      axi_wr(ba(RSD_IDX_REG_TIMER + 8'(k)), 32'h0000_00a5, r);
      check({30'h0000_0000, r}, {30'h0000_0000, RSD_RESP_OKAY});
    end
    rd_chk(RSD_IDX_PEAKS, {24'h0000_00, pa, pp});
    rd_chk(RSD_IDX_REG_TIMER, {24'h0000_00, code, 1'b0, timers});
    check(32'(n_default), 32'h0000_0000);
    rd_chk(RSD_IDX_RSVD_A, 32'h0000_0000);
    rd_chk(RSD_IDX_RSVD_B, 32'h0000_0000);
    axi_rd(10'h200, d, r);
    check(d, 32'h0000_0000);
    check({30'h0000_0000, r}, {30'h0000_0000, RSD_RESP_SLVERR});
    axi_wr(10'h200, 32'h0000_0003, r);
    check({30'h0000_0000, r}, {30'h0000_0000, RSD_RESP_SLVERR});
    $display("test access kinds done");
    axi_wr(ba(RSD_IDX_CTRL), 32'h0000_0002, r);
    check(32'(n_default), 32'h0000_0000);
    rd_chk(RSD_IDX_PEAKS, 32'h0000_0000);
    src_ext <= 1'b0; adj_done <= 1'b1; adj_code <= 4'h7; lvl <= 8'h99; level_valid <= 1'b1; timers <= '0;
    tick(1);
    adj_done <= 1'b0; level_valid <= 1'b0;
    rd_chk(RSD_IDX_REG_TIMER, 32'h0000_0070);
    rd_chk(RSD_IDX_PEAKS, 32'h0000_0099);
    axi_wr(ba(RSD_IDX_CTRL), 32'h0000_0001, r);
    check(32'(n_default), 32'h0000_0001);
    rd_chk(RSD_IDX_REG_TIMER, 32'h0000_00f0);
    rd_chk(RSD_IDX_PEAKS, 32'h0000_0000);
    $display("test clear and default done");
    give_verdict();
  end
endmodule
